// ===== rtl/lfx_coeff_map.vh
`ifndef LFX_COEFF_MAP_VH
`define LFX_COEFF_MAP_VH

// register indices on page 1
`define LFX_OFS_NUM4_HIGH   8'h09
`define LFX_OFS_NUM4_LOW    8'h0a
`define LFX_OFS_NUM5_HIGH   8'h0b
`define LFX_OFS_NUM5_LOW    8'h0c
`define LFX_OFS_DEN1_HIGH   8'h0d
`define LFX_OFS_DEN1_LOW    8'h0e
`define LFX_OFS_DEN2_HIGH   8'h0f
`define LFX_OFS_DEN2_LOW    8'h10
`define LFX_OFS_DEN4_HIGH   8'h11
`define LFX_OFS_DEN4_LOW    8'h12
`define LFX_OFS_FIRST       8'h09
`define LFX_OFS_LAST        8'h12

// reset values
`define LFX_RST_NUM4_HIGH   8'h96
`define LFX_RST_NUM4_LOW    8'h66
`define LFX_RST_NUM5_HIGH   8'h67
`define LFX_RST_NUM5_LOW    8'h5d
`define LFX_RST_DEN1_HIGH   8'h7d
`define LFX_RST_DEN1_LOW    8'h83
`define LFX_RST_DEN2_HIGH   8'h84
`define LFX_RST_DEN2_LOW    8'hee
`define LFX_RST_DEN4_HIGH   8'h7d
`define LFX_RST_DEN4_LOW    8'h83

// field layout of a coefficient pair
`define LFX_COEFF_HIGH_MSB  15
`define LFX_COEFF_HIGH_LSB  8
`define LFX_COEFF_LOW_MSB   7
`define LFX_COEFF_LOW_LSB   0

`endif

// ===== rtl/lfx_coeff_regs.v
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "lfx_coeff_map.vh"

module lfx_coeff_regs (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    output reg  [15:0] numerator_coeff_four,
    output reg  [15:0] numerator_coeff_five,
    output reg  [15:0] denominator_coeff_one,
    output reg  [15:0] denominator_coeff_two,
    output reg  [15:0] denominator_coeff_four,
    output reg         coeff_update
);

////////////////////////////////////////////////////////////////////////////////
// sizes

localparam NREG   = 10; // byte registers held, index 9 up to 18
localparam BYTE_W = 8;
localparam COEF_W = 16;

////////////////////////////////////////////////////////////////////////////////
// slot numbers inside the byte store; slot 0 is index 9

localparam SLOT_NUM4_HIGH = 0;
localparam SLOT_NUM4_LOW  = 1;

localparam SLOT_NUM5_HIGH = 2;
localparam SLOT_NUM5_LOW  = 3;

localparam SLOT_DEN1_HIGH = 4;
localparam SLOT_DEN1_LOW  = 5;

localparam SLOT_DEN2_HIGH = 6;
localparam SLOT_DEN2_LOW  = 7;

localparam SLOT_DEN4_HIGH = 8;
localparam SLOT_DEN4_LOW  = 9;

////////////////////////////////////////////////////////////////////////////////
// reset image of each published pair

localparam [COEF_W-1:0] RST_NUM4 = {`LFX_RST_NUM4_HIGH, `LFX_RST_NUM4_LOW};
localparam [COEF_W-1:0] RST_NUM5 = {`LFX_RST_NUM5_HIGH, `LFX_RST_NUM5_LOW};
localparam [COEF_W-1:0] RST_DEN1 = {`LFX_RST_DEN1_HIGH, `LFX_RST_DEN1_LOW};
localparam [COEF_W-1:0] RST_DEN2 = {`LFX_RST_DEN2_HIGH, `LFX_RST_DEN2_LOW};
localparam [COEF_W-1:0] RST_DEN4 = {`LFX_RST_DEN4_HIGH, `LFX_RST_DEN4_LOW};

////////////////////////////////////////////////////////////////////////////////
// write decode: one enable per byte register by exact index match, so any
// index outside 9..18 matches none and the write is dropped

wire [NREG-1:0] slot_wr;

assign slot_wr[SLOT_NUM4_HIGH] = reg_write && (reg_addr == `LFX_OFS_NUM4_HIGH);
assign slot_wr[SLOT_NUM4_LOW]  = reg_write && (reg_addr == `LFX_OFS_NUM4_LOW);

assign slot_wr[SLOT_NUM5_HIGH] = reg_write && (reg_addr == `LFX_OFS_NUM5_HIGH);
assign slot_wr[SLOT_NUM5_LOW]  = reg_write && (reg_addr == `LFX_OFS_NUM5_LOW);

assign slot_wr[SLOT_DEN1_HIGH] = reg_write && (reg_addr == `LFX_OFS_DEN1_HIGH);
assign slot_wr[SLOT_DEN1_LOW]  = reg_write && (reg_addr == `LFX_OFS_DEN1_LOW);

assign slot_wr[SLOT_DEN2_HIGH] = reg_write && (reg_addr == `LFX_OFS_DEN2_HIGH);
assign slot_wr[SLOT_DEN2_LOW]  = reg_write && (reg_addr == `LFX_OFS_DEN2_LOW);

assign slot_wr[SLOT_DEN4_HIGH] = reg_write && (reg_addr == `LFX_OFS_DEN4_HIGH);
assign slot_wr[SLOT_DEN4_LOW]  = reg_write && (reg_addr == `LFX_OFS_DEN4_LOW);

////////////////////////////////////////////////////////////////////////////////
// reset byte of each slot

function [BYTE_W-1:0] reset_byte;
    input integer slot;
    begin
        case (slot)
            SLOT_NUM4_HIGH: reset_byte = `LFX_RST_NUM4_HIGH;
            SLOT_NUM4_LOW:  reset_byte = `LFX_RST_NUM4_LOW;

            SLOT_NUM5_HIGH: reset_byte = `LFX_RST_NUM5_HIGH;
            SLOT_NUM5_LOW:  reset_byte = `LFX_RST_NUM5_LOW;

            SLOT_DEN1_HIGH: reset_byte = `LFX_RST_DEN1_HIGH;
            SLOT_DEN1_LOW:  reset_byte = `LFX_RST_DEN1_LOW;

            SLOT_DEN2_HIGH: reset_byte = `LFX_RST_DEN2_HIGH;
            SLOT_DEN2_LOW:  reset_byte = `LFX_RST_DEN2_LOW;

            SLOT_DEN4_HIGH: reset_byte = `LFX_RST_DEN4_HIGH;
            SLOT_DEN4_LOW:  reset_byte = `LFX_RST_DEN4_LOW;
            default:        reset_byte = 8'h00;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// byte store: one flop byte per register, flattened and addressed by slot

wire [NREG*BYTE_W-1:0] store;

genvar g;
generate
    for (g = 0; g < NREG; g = g + 1) begin : g_byte
        reg [BYTE_W-1:0] byte_q;
        // the reset image is a constant per slot
        always @(posedge sys_clk) begin
            if (reset)
                byte_q <= reset_byte(g);
            else if (slot_wr[g])
                byte_q <= reg_wdata;
        end
        assign store[BYTE_W*g +: BYTE_W] = byte_q;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// named views of the stored bytes

wire [BYTE_W-1:0] num4_high_q = store[BYTE_W*SLOT_NUM4_HIGH +: BYTE_W];
wire [BYTE_W-1:0] num4_low_q  = store[BYTE_W*SLOT_NUM4_LOW  +: BYTE_W];

wire [BYTE_W-1:0] num5_high_q = store[BYTE_W*SLOT_NUM5_HIGH +: BYTE_W];
wire [BYTE_W-1:0] num5_low_q  = store[BYTE_W*SLOT_NUM5_LOW  +: BYTE_W];

wire [BYTE_W-1:0] den1_high_q = store[BYTE_W*SLOT_DEN1_HIGH +: BYTE_W];
wire [BYTE_W-1:0] den1_low_q  = store[BYTE_W*SLOT_DEN1_LOW  +: BYTE_W];

wire [BYTE_W-1:0] den2_high_q = store[BYTE_W*SLOT_DEN2_HIGH +: BYTE_W];
wire [BYTE_W-1:0] den2_low_q  = store[BYTE_W*SLOT_DEN2_LOW  +: BYTE_W];

wire [BYTE_W-1:0] den4_high_q = store[BYTE_W*SLOT_DEN4_HIGH +: BYTE_W];
wire [BYTE_W-1:0] den4_low_q  = store[BYTE_W*SLOT_DEN4_LOW  +: BYTE_W];

////////////////////////////////////////////////////////////////////////////////
// read port: data stand for the one cycle after the strobe and read as zero
// otherwise, so an unmapped index never returns stale data

reg [BYTE_W-1:0] next_rdata;

always @* begin
    next_rdata = 8'h00;
    if (reg_read) begin
        case (reg_addr)
            `LFX_OFS_NUM4_HIGH: next_rdata = num4_high_q;
            `LFX_OFS_NUM4_LOW:  next_rdata = num4_low_q;

            `LFX_OFS_NUM5_HIGH: next_rdata = num5_high_q;
            `LFX_OFS_NUM5_LOW:  next_rdata = num5_low_q;

            `LFX_OFS_DEN1_HIGH: next_rdata = den1_high_q;
            `LFX_OFS_DEN1_LOW:  next_rdata = den1_low_q;

            `LFX_OFS_DEN2_HIGH: next_rdata = den2_high_q;
            `LFX_OFS_DEN2_LOW:  next_rdata = den2_low_q;

            `LFX_OFS_DEN4_HIGH: next_rdata = den4_high_q;
            `LFX_OFS_DEN4_LOW:  next_rdata = den4_low_q;
            default:            next_rdata = 8'h00;
        endcase
    end
end

always @(posedge sys_clk) begin
    if (reset)
        reg_rdata <= 8'h00;
    else
        reg_rdata <= next_rdata;
end

////////////////////////////////////////////////////////////////////////////////
// coefficient publish: a pair reaches the filter only when its low byte
// lands, together with the high byte already stored, so the filter never
// works with a half-updated value; the new low byte is taken straight from
// the bus because its own flop updates on the same edge

// numerator coefficient four
// high byte at index 9, low byte at index 10
wire              pub_num4 = slot_wr[SLOT_NUM4_LOW];
reg  [COEF_W-1:0] next_num4;

always @* begin
    next_num4 = numerator_coeff_four;
    if (pub_num4)
        next_num4 = {num4_high_q, reg_wdata};
end

always @(posedge sys_clk) begin
    if (reset)
        numerator_coeff_four <= RST_NUM4;
    else
        numerator_coeff_four <= next_num4;
end

// numerator coefficient five
// high byte at index 11, low byte at index 12
wire              pub_num5 = slot_wr[SLOT_NUM5_LOW];
reg  [COEF_W-1:0] next_num5;

always @* begin
    next_num5 = numerator_coeff_five;
    if (pub_num5)
        next_num5 = {num5_high_q, reg_wdata};
end

always @(posedge sys_clk) begin
    if (reset)
        numerator_coeff_five <= RST_NUM5;
    else
        numerator_coeff_five <= next_num5;
end

// denominator coefficient one
// high byte at index 13, low byte at index 14
wire              pub_den1 = slot_wr[SLOT_DEN1_LOW];
reg  [COEF_W-1:0] next_den1;

always @* begin
    next_den1 = denominator_coeff_one;
    if (pub_den1)
        next_den1 = {den1_high_q, reg_wdata};
end

always @(posedge sys_clk) begin
    if (reset)
        denominator_coeff_one <= RST_DEN1;
    else
        denominator_coeff_one <= next_den1;
end

// denominator coefficient two
// high byte at index 15, low byte at index 16
wire              pub_den2 = slot_wr[SLOT_DEN2_LOW];
reg  [COEF_W-1:0] next_den2;

always @* begin
    next_den2 = denominator_coeff_two;
    if (pub_den2)
        next_den2 = {den2_high_q, reg_wdata};
end

always @(posedge sys_clk) begin
    if (reset)
        denominator_coeff_two <= RST_DEN2;
    else
        denominator_coeff_two <= next_den2;
end

// denominator coefficient four
// high byte at index 17, low byte at index 18
wire              pub_den4 = slot_wr[SLOT_DEN4_LOW];
reg  [COEF_W-1:0] next_den4;

always @* begin
    next_den4 = denominator_coeff_four;
    if (pub_den4)
        next_den4 = {den4_high_q, reg_wdata};
end

always @(posedge sys_clk) begin
    if (reset)
        denominator_coeff_four <= RST_DEN4;
    else
        denominator_coeff_four <= next_den4;
end

////////////////////////////////////////////////////////////////////////////////
// limitation: a low write with no fresh high write publishes the stored high
// byte beside the new low byte; a high write never reaches the filter on its
// own, so software that skips the low write leaves the filter on the old pair

////////////////////////////////////////////////////////////////////////////////
// update strobe: pulses for one cycle after any low-byte write, in step with
// the coefficient that it announces, so the filter can latch the pair on it
// without comparing values

wire low_wr = pub_num4 | pub_num5 | pub_den1 | pub_den2 | pub_den4;

always @(posedge sys_clk) begin
    if (reset)
        coeff_update <= 1'b0;
    else
        coeff_update <= low_wr;
end

endmodule // lfx_coeff_regs
`default_nettype wire

// ===== verif/lfx_coeff_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lfx_coeff_props(input wire sys_clk,reset,reg_write,reg_read,coeff_update,input wire [7:0] reg_addr,reg_wdata,
    reg_rdata,input wire [15:0] numerator_coeff_four,numerator_coeff_five,denominator_coeff_one,
    denominator_coeff_two,denominator_coeff_four);
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
wire lw = reg_write && reg_addr inside {8'h0a,8'h0c,8'h0e,8'h10,8'h12};
wire [79:0] cf = {numerator_coeff_four,numerator_coeff_five,denominator_coeff_one,denominator_coeff_two,
    denominator_coeff_four};
upd_pulse_a: assert property(lw |=> coeff_update) else $error("no update after low write");
upd_quiet_a: assert property(!lw |=> !coeff_update && $stable(cf)) else $error("coefficient moved");
rst_vals_a:
assert property($fell(reset) |-> cf == 80'h9666_675d_7d83_84ee_7d83) else $error("bad reset value");
pair_value_a:
assert property(reg_write && reg_addr == 8'h0b ##1 reg_write && reg_addr == 8'h0c |=>
    numerator_coeff_five == {$past(reg_wdata,2),$past(reg_wdata)}) else $error("bad pair value");
low_pub_a:
assert property(reg_write && reg_addr == 8'h12 |=> denominator_coeff_four[7:0] == $past(reg_wdata)) else $error("low");
rd_idle_a: assert property(!reg_read |=> reg_rdata == 8'h00) else $error("stray read data");
rd_back_a:
assert property(reg_write && reg_addr inside {[8'h09:8'h12]} ##1 reg_read && reg_addr == $past(reg_addr) |=>
    reg_rdata == $past(reg_wdata,2)) else $error("bad readback");
unmapped_a:
assert property(reg_read && !(reg_addr inside {[8'h09:8'h12]}) |=> reg_rdata == 8'h00) else $error("unmapped");
cover property(lw);
cover property(reg_read && reg_addr == 8'h13);
cover property($fell(reset));
endmodule // lfx_coeff_props
`default_nettype wire

// ===== verif/lfx_coeff_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lfx_coeff_regs_tb_top;
logic sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0, coeff_update;
logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
logic [15:0] n4, n5, d1, d2, d4;
int n_fail = 0, total_checks = 0;
localparam [79:0] RV = 80'h9666_675d_7d83_84ee_7d83;
always #5 sys_clk = ~sys_clk;
lfx_coeff_regs i_lfx_coeff_regs(.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .numerator_coeff_four(n4), .numerator_coeff_five(n5), .denominator_coeff_one(d1),
    .denominator_coeff_two(d2), .denominator_coeff_four(d4), .coeff_update);
task cmp(input [15:0] g, e); total_checks++;
    if (g !== e) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, g, e); end endtask
task wr(input [7:0] a, d); @(posedge sys_clk); reg_addr <= a; reg_wdata <= d; reg_write <= 1; endtask
// strobes drop here, so back-to-back requests simply skip this task
task idle; @(posedge sys_clk); reg_write <= 0; reg_read <= 0; #1; endtask
task rd(input [7:0] a, e); @(posedge sys_clk); reg_addr <= a; reg_read <= 1; reg_write <= 0; idle; cmp(reg_rdata, e);
endtask
task t_reset; for (int i = 9; i < 19; i++) rd(i, RV[8*(18-i)+:8]);
    cmp({n4,n5,d1,d2,d4} == RV, 1); endtask
task t_pairs; for (int k = 0; k < 5; k++) begin
    wr(9 + 2*k, 8'h80 + k); wr(10 + 2*k, 8'h10 + k); idle;
    cmp({n4,n5,d1,d2,d4} >> (16*(4-k)), 16'h8010 + 16'h0101*k); cmp(coeff_update, 1);
end endtask
// the high byte stays hidden until the low byte that follows it lands
task t_half; wr(8'h0b, 8'h55); wr(8'h0c, 8'h22); #1 cmp(n5, 16'h8111); cmp(coeff_update, 0);
    rd(8'h0c, 8'h22); cmp(n5, 16'h5522); rd(8'h0b, 8'h55); endtask
task t_unmapped; wr(8'h13, 8'haa); wr(8'h08, 8'hbb); idle; rd(8'h13, 0); rd(8'h08, 0);
    rd(8'h09, 8'h80); rd(8'h12, 8'h14); endtask
task tally_and_finish; $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish; endtask
initial begin repeat (10) @(posedge sys_clk); reset <= 0;
    t_reset; t_pairs; t_half; t_unmapped;
    @(posedge sys_clk) reset <= 1; repeat (3) @(posedge sys_clk); reset <= 0;
    t_reset; tally_and_finish; end
endmodule // lfx_coeff_regs_tb_top
bind lfx_coeff_regs lfx_coeff_props i_lfx_coeff_props(.*);
`default_nettype wire
